/* src/sacc_consts.svh */
// register map, field positions, reset values and conversion counts of the converter control
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH
`define SACC_OFS_CHSEL   8'h00
`define SACC_OFS_CTRLA   8'h04
`define SACC_OFS_CTRLB   8'h08
`define SACC_OFS_RESLO   8'h0C
`define SACC_OFS_RESHI   8'h10
`define SACC_OFS_MISC    8'h14
`define SACC_CH_LSB      0
`define SACC_CH_MSB      4
`define SACC_LADJ_BIT    5
`define SACC_REF_LSB     6
`define SACC_REF_MSB     7
`define SACC_EN_BIT      7
`define SACC_SC_BIT      6
`define SACC_ATE_BIT     5
`define SACC_FLAG_BIT    4
`define SACC_IE_BIT      3
`define SACC_PS_LSB      0
`define SACC_PS_MSB      2
`define SACC_TS_LSB      0
`define SACC_TS_MSB      2
`define SACC_CSRC_BIT    0
`define SACC_XREF_BIT    1
`define SACC_REFERENCE_PIN_BIT    2
`define SACC_CHSEL_RST   8'h00
`define SACC_CTRLA_RST   8'h00
`define SACC_CTRLB_RST   8'h00
`define SACC_MISC_RST    8'h00
`define SACC_TS_SELF     3'h0
`define SACC_CONV_NORMAL 5'h0D
`define SACC_CONV_FIRST  5'h19
`define SACC_HOLD_NORMAL 5'h01
`define SACC_HOLD_FIRST  5'h0D
`define SACC_DIFF_BIT    4
`endif

/* src/sacc_pkg.sv */
// types shared by the converter control
package sacc_pkg;
	typedef enum logic [0:0] {
		SACC_IDLE = 1'h0,
		SACC_CONV = 1'h1
	} sacc_state_t;
	typedef enum logic [2:0] {
		SACC_REG_CHSEL = 3'h0,
		SACC_REG_CTRLA = 3'h1,
		SACC_REG_CTRLB = 3'h2,
		SACC_REG_RESLO = 3'h3,
		SACC_REG_RESHI = 3'h4,
		SACC_REG_MISC  = 3'h5,
		SACC_REG_NONE  = 3'h7
	} sacc_reg_t;
endpackage

/* src/sacc_top.sv */
// digital control of a 10-bit successive approximation converter with APB registers
`timescale 1ns/1ns
`include "sacc_consts.svh"

// Behaviour
// - converter works and applies selections only when enabled
// - result right aligned, left aligned when left_adjust set
// - low byte read blocks result updates
// - completion while blocked discards result, bytes unchanged
// - high byte read lifts the block
// - completion always raises done flag, and interrupt when its enable is set
// - done flag raised even when result discarded
// - start bit starts conversion, cleared at completion except when free running
// - channel change applies only after running conversion
// - auto_trigger_enable starts conversions from selected source
// - trigger rising edge resets prescaler, starts conversion
// - trigger level at completion starts nothing
// - trigger edges during conversion are ignored
// - trigger flags set regardless of interrupt enables
// - own done flag as source gives free running
// - start bit works on demand with auto trigger
// - start bit reads one during every conversion
// - channel code selects single/differential and gain
// - channel code reaches 11 pins, temperature, current source
// - reference from reference_select and external pin enable
// - conversion 13 converter clocks, first 25
// - completion writes result unless blocked, sets flag, clears start unless free running
// - prescaler runs only while enabled
// - software start begins at next converter clock edge
module sacc_top #(
	parameter int TRIG_W = 7
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              reset_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// trigger sources, codes 1 to 7 of trigger_select
	input  wire logic [TRIG_W-1:0] trig_src,
	// analog section
	input  wire logic [9:0]        ana_result,
	output logic                   ana_enable,
	output logic [4:0]             ana_channel,
	output logic                   ana_diff,
	output logic                   ana_gain_20x,
	output logic [1:0]             ana_ref_sel,
	output logic                   ana_ref_ext,
	output logic                   ana_ref_out,
	output logic                   ana_current_source_pin_en,
	output logic                   ana_hold,
	// conversion complete interrupt
	output logic                   conv_irq
);

	logic                rst_s1_reg;
	logic                rst_n;
	logic [7:0]          chsel_reg;
	logic [7:0]          ctrla_reg;
	logic [2:0]          tsel_reg;
	logic [7:0]          misc_reg;
	logic [9:0]          res_reg;
	logic                lock_reg;
	logic                flag_reg;
	logic                start_reg;
	logic                first_reg;
	logic [7:0]          presc_reg;
	logic                tick;
	logic [4:0]          cnt_reg;
	logic [4:0]          len_reg;
	logic [4:0]          hold_pt_reg;
	sacc_pkg::sacc_state_t state_reg;
	logic [TRIG_W-1:0]   trig_s1_reg;
	logic [TRIG_W-1:0]   trig_s2_reg;
	logic                trig_prev_reg;
	logic                trig_cur;
	logic                trig_edge;
	logic                busy;
	logic                trig_go;
	logic                sw_start;
	logic                done;
	logic                free_run;
	logic                en;
	logic                acc;
	logic                setup;
	sacc_pkg::sacc_reg_t sel;
	logic [7:0]          rdata;

	// register select from the word address; misaligned low bits are ignored
	function automatic sacc_pkg::sacc_reg_t reg_decode(input logic [7:0] a);
		unique case ({a[7:2], 2'h0})
			`SACC_OFS_CHSEL: reg_decode = sacc_pkg::SACC_REG_CHSEL;
			`SACC_OFS_CTRLA: reg_decode = sacc_pkg::SACC_REG_CTRLA;
			`SACC_OFS_CTRLB: reg_decode = sacc_pkg::SACC_REG_CTRLB;
			`SACC_OFS_RESLO: reg_decode = sacc_pkg::SACC_REG_RESLO;
			`SACC_OFS_RESHI: reg_decode = sacc_pkg::SACC_REG_RESHI;
			`SACC_OFS_MISC:  reg_decode = sacc_pkg::SACC_REG_MISC;
			default:         reg_decode = sacc_pkg::SACC_REG_NONE;
		endcase
	endfunction

	// reset release through two flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_reg <= 1'h0;
			rst_n      <= 1'h0;
		end
		else
		begin
			rst_s1_reg <= 1'h1;
			rst_n      <= rst_s1_reg;
		end
	end

	// bus phases; every access completes one cycle after setup
	assign sel   = reg_decode(paddr);
	assign setup = psel & ~penable;
	assign acc   = psel & penable & pready;
	assign en    = ctrla_reg[`SACC_EN_BIT];
	assign sw_start = acc & pwrite & (sel == sacc_pkg::SACC_REG_CTRLA)
		& pwdata[`SACC_SC_BIT] & pwdata[`SACC_EN_BIT];

	// control registers written at the access edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chsel_reg <= `SACC_CHSEL_RST;
			ctrla_reg <= `SACC_CTRLA_RST;
			tsel_reg  <= 3'h0;
			misc_reg  <= `SACC_MISC_RST;
		end
		else if (acc && pwrite)
		begin
			unique case (sel)
				sacc_pkg::SACC_REG_CHSEL: chsel_reg <= pwdata[7:0];
				sacc_pkg::SACC_REG_CTRLA: ctrla_reg <= pwdata[7:0];
				sacc_pkg::SACC_REG_CTRLB: tsel_reg  <= pwdata[`SACC_TS_MSB:`SACC_TS_LSB];
				sacc_pkg::SACC_REG_MISC:  misc_reg  <= pwdata[7:0];
				default:                  ;
			endcase
		end
	end

	// trigger sources come from other logic and pins, so two flops first
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_s1_reg   <= '0;
			trig_s2_reg   <= '0;
			trig_prev_reg <= 1'h0;
		end
		else
		begin
			trig_s1_reg   <= trig_src;
			trig_s2_reg   <= trig_s1_reg;
			trig_prev_reg <= trig_cur;
		end
	end

	// selected external trigger and its rising edge
	always_comb
	begin
		trig_cur = 1'h0;
		if (tsel_reg != `SACC_TS_SELF)
			trig_cur = trig_s2_reg[tsel_reg - 3'h1];
	end
	assign trig_edge = trig_cur & ~trig_prev_reg;
	assign free_run  = ctrla_reg[`SACC_ATE_BIT] & (tsel_reg == `SACC_TS_SELF);
	assign busy      = start_reg | (state_reg == sacc_pkg::SACC_CONV);
	// edges while busy are dropped, nothing is queued
	assign trig_go   = en & ctrla_reg[`SACC_ATE_BIT] & trig_edge & ~busy;

	// converter clock prescaler, divide by 2 to 256
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			presc_reg <= 8'h00;
		else if (!en || trig_go)
			presc_reg <= 8'h00;
		else if (tick)
			presc_reg <= 8'h00;
		else
			presc_reg <= presc_reg + 8'h01;
	end
	assign tick = en && (presc_reg ==
		8'((9'h002 << ctrla_reg[`SACC_PS_MSB:`SACC_PS_LSB]) - 9'h001));

	// completion on the last converter clock of a conversion
	assign done = (state_reg == sacc_pkg::SACC_CONV) && tick && (cnt_reg == len_reg - 5'h01);

	// start request held until the conversion ends, kept on while free running; reads as the start bit
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			start_reg <= 1'h0;
		else if (!en)
			start_reg <= 1'h0;
		else if (sw_start || trig_go)
			start_reg <= 1'h1;
		else if (done && !free_run)
			start_reg <= 1'h0;
	end

	// sequencer: begins on the converter clock after the request
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= sacc_pkg::SACC_IDLE;
			cnt_reg     <= 5'h00;
			len_reg     <= `SACC_CONV_NORMAL;
			hold_pt_reg <= `SACC_HOLD_NORMAL;
		end
		else if (!en)
			state_reg <= sacc_pkg::SACC_IDLE;
		else
		begin
			unique case (state_reg)
				sacc_pkg::SACC_IDLE:
				begin
					if (start_reg && tick)
					begin
						state_reg   <= sacc_pkg::SACC_CONV;
						cnt_reg     <= 5'h00;
						len_reg     <= first_reg ? `SACC_CONV_FIRST : `SACC_CONV_NORMAL;
						hold_pt_reg <= first_reg ? `SACC_HOLD_FIRST : `SACC_HOLD_NORMAL;
					end
				end
				sacc_pkg::SACC_CONV:
				begin
					if (done)
					begin
						// free running restarts at once; software begins the first
						state_reg   <= free_run ? sacc_pkg::SACC_CONV : sacc_pkg::SACC_IDLE;
						cnt_reg     <= 5'h00;
						len_reg     <= `SACC_CONV_NORMAL;
						hold_pt_reg <= `SACC_HOLD_NORMAL;
					end
					else if (tick)
						cnt_reg <= cnt_reg + 5'h01;
				end
			endcase
		end
	end

	// first conversion after enabling takes the long initialisation
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			first_reg <= 1'h1;
		else if (!en)
			first_reg <= 1'h1;
		else if (done)
			first_reg <= 1'h0;
	end

	// result capture; a low read blocks from its setup edge on, so data stays paired
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			res_reg <= 10'h000;
		else if (done && !lock_reg
			&& !(psel && !pwrite && sel == sacc_pkg::SACC_REG_RESLO))
			res_reg <= ana_result;
	end

	// read-order lock between low and high byte
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			lock_reg <= 1'h0;
		else if (acc && !pwrite && sel == sacc_pkg::SACC_REG_RESHI)
			lock_reg <= 1'h0;
		else if (acc && !pwrite && sel == sacc_pkg::SACC_REG_RESLO)
			lock_reg <= 1'h1;
	end

	// done flag: set even when discarded or interrupt masked; set beats clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			flag_reg <= 1'h0;
		else if (done)
			flag_reg <= 1'h1;
		else if (acc && pwrite && sel == sacc_pkg::SACC_REG_CTRLA && pwdata[`SACC_FLAG_BIT])
			flag_reg <= 1'h0;
	end

	// interrupt line from the flag and its enable
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			conv_irq <= 1'h0;
		else
			conv_irq <= flag_reg & ctrla_reg[`SACC_IE_BIT];
	end

	// selections follow the register while enabled and idle, and at completion for free running
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ana_channel  <= 5'h00;
			ana_diff     <= 1'h0;
			ana_gain_20x <= 1'h0;
			ana_ref_sel  <= 2'h0;
			ana_ref_ext  <= 1'h0;
		end
		else if (en && (state_reg == sacc_pkg::SACC_IDLE || done))
		begin
			ana_channel  <= chsel_reg[`SACC_CH_MSB:`SACC_CH_LSB];
			ana_diff     <= chsel_reg[`SACC_DIFF_BIT];
			ana_gain_20x <= chsel_reg[`SACC_DIFF_BIT] & chsel_reg[0];
			ana_ref_sel  <= chsel_reg[`SACC_REF_MSB:`SACC_REF_LSB];
			ana_ref_ext  <= misc_reg[`SACC_REFERENCE_PIN_BIT];
		end
	end

	// analog enables and sample-and-hold strobe
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ana_enable  <= 1'h0;
			ana_ref_out <= 1'h0;
			ana_current_source_pin_en <= 1'h0;
			ana_hold    <= 1'h0;
		end
		else
		begin
			ana_enable  <= en;
			ana_ref_out <= misc_reg[`SACC_XREF_BIT];
			ana_current_source_pin_en <= misc_reg[`SACC_CSRC_BIT];
			ana_hold    <= (state_reg == sacc_pkg::SACC_CONV) && !done
				&& (cnt_reg >= hold_pt_reg);
		end
	end

	// read mux with alignment applied on the way out
	always_comb
	begin
		rdata = 8'h00;
		unique case (sel)
			sacc_pkg::SACC_REG_CHSEL: rdata = chsel_reg;
			sacc_pkg::SACC_REG_CTRLA: rdata = {en, busy, ctrla_reg[5], flag_reg,
				ctrla_reg[3:0]};
			sacc_pkg::SACC_REG_CTRLB: rdata = {5'h00, tsel_reg};
			sacc_pkg::SACC_REG_RESLO: rdata = chsel_reg[`SACC_LADJ_BIT]
				? {res_reg[1:0], 6'h00} : res_reg[7:0];
			sacc_pkg::SACC_REG_RESHI: rdata = chsel_reg[`SACC_LADJ_BIT]
				? res_reg[9:2] : {6'h00, res_reg[9:8]};
			sacc_pkg::SACC_REG_MISC:  rdata = misc_reg;
			default:                  rdata = 8'h00;
		endcase
	end

	// bus answer registered during setup; unmapped addresses report an error
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'h0;
			prdata  <= 32'h00000000;
			pslverr <= 1'h0;
		end
		else
		begin
			pready  <= setup;
			prdata  <= setup ? {24'h000000, rdata} : 32'h00000000;
			pslverr <= setup && (sel == sacc_pkg::SACC_REG_NONE);
		end
	end

	default clocking sacc_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_start_reads_busy: assert property (state_reg == sacc_pkg::SACC_CONV |-> start_reg)
		else $error("start bit low during conversion");
	a_lock_keeps_result: assert property (lock_reg && done |=> $stable(res_reg))
		else $error("locked result overwritten");
	a_done_sets_flag: assert property (done |=> flag_reg)
		else $error("done flag not set at completion");
	a_high_read_unlocks: assert property (acc && !pwrite && sel == sacc_pkg::SACC_REG_RESHI
		|=> !lock_reg)
		else $error("high read left lock set");
	a_disabled_idle: assert property (!en |=> state_reg == sacc_pkg::SACC_IDLE && !start_reg)
		else $error("converter active while disabled");
	a_prescaler_held: assert property (!en |=> presc_reg == 8'h00)
		else $error("prescaler ran while disabled");
	a_channel_locked: assert property (state_reg == sacc_pkg::SACC_CONV
		&& $past(state_reg) == sacc_pkg::SACC_CONV && !$past(done) |-> $stable(ana_channel))
		else $error("channel changed mid conversion");
	a_single_clears: assert property (done && !free_run && !sw_start && !trig_go
		|=> !start_reg && state_reg == sacc_pkg::SACC_IDLE)
		else $error("single conversion did not end");
	a_trigger_starts: assert property (trig_go |=> start_reg && presc_reg == 8'h00)
		else $error("trigger edge did not start");
	a_free_run_restarts: assert property (done && free_run && en
		|=> state_reg == sacc_pkg::SACC_CONV && cnt_reg == 5'h00)
		else $error("free running did not restart");
	a_length_normal: assert property (state_reg == sacc_pkg::SACC_CONV
		|-> len_reg == (first_reg ? `SACC_CONV_FIRST : `SACC_CONV_NORMAL))
		else $error("bad conversion length");
	a_edge_ignored: assert property (busy && trig_edge && state_reg == sacc_pkg::SACC_CONV
		&& !done |=> state_reg == sacc_pkg::SACC_CONV && $stable(len_reg))
		else $error("edge disturbed running conversion");

endmodule // sacc_top

/* tb/sacc_analog_model.sv */
// behavioural analog section: answers with a code built from the locked selections
`timescale 1ns/1ns
module sacc_analog_model (
	// clock
	input  wire logic       mclk,
	// selections and hold from the control
	input  wire logic [4:0] ana_channel,
	input  wire logic       ana_diff,
	input  wire logic       ana_gain_20x,
	input  wire logic [1:0] ana_ref_sel,
	input  wire logic       ana_hold,
	// result to the control
	output logic      [9:0] ana_result
);
	logic [9:0] held;
	logic [9:0] code;

	// code mirrors the selections, so a wrong channel, gain or reference shows up
	assign code = {ana_gain_20x, ana_diff, ana_ref_sel, ana_channel, 1'h1};

	// remember the last code so the released line can show its inverse
	always_ff @(posedge mclk)
	begin
		if (ana_hold)
			held <= code;
	end

	// outside the hold window the line never shows a stale good value
	assign ana_result = ana_hold ? code : ~held;
endmodule // sacc_analog_model

/* tb/sacc_top_tb_top.sv */
// testbench of the converter control: apb traffic, triggers and result checks
`timescale 1ns/1ns
module sacc_top_tb_top;
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  trig_src;
	logic [9:0]  ana_result, code;
	logic        ana_enable, ana_diff, ana_gain_20x, ana_ref_ext, ana_ref_out;
	logic        ana_current_source_pin_en, ana_hold, conv_irq;
	logic [4:0]  ana_channel, ch;
	logic [1:0]  ana_ref_sel, rf;
	int          bad_count, num_checks;

	sacc_top sacc_top_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .trig_src(trig_src), .ana_result(ana_result),
		.ana_enable(ana_enable), .ana_channel(ana_channel), .ana_diff(ana_diff),
		.ana_gain_20x(ana_gain_20x), .ana_ref_sel(ana_ref_sel), .ana_ref_ext(ana_ref_ext),
		.ana_ref_out(ana_ref_out), .ana_current_source_pin_en(ana_current_source_pin_en), .ana_hold(ana_hold),
		.conv_irq(conv_irq));

	sacc_analog_model sacc_analog_model_inst (.mclk(mclk), .ana_channel(ana_channel),
		.ana_diff(ana_diff), .ana_gain_20x(ana_gain_20x), .ana_ref_sel(ana_ref_sel),
		.ana_hold(ana_hold), .ana_result(ana_result));

	// 25 MHz clock
	always #20 mclk = ~mclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; an idle edge first so psel never moves twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		// no cycle count assumed; a hang is ended by the watchdog
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// poll the done flag, bounded
	task automatic wait_done;
		int n;
		n = 0;
		do
		begin
			apb(1'h0, 8'h04, 32'h0);
			n++;
		end
		while (rd[4] !== 1'h1 && n < 200);
		chk(32'(rd[4]), 32'h1);
	endtask

	function automatic logic [9:0] expc(input logic [4:0] c, input logic [1:0] r);
		return {c[4] & c[0], c[4], r, c, 1'h1};
	endfunction

	task automatic end_of_test;
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#2000000;
		bad_count++;
		end_of_test();
	end

	initial
	begin
		mclk = 1'h0;
		reset_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		trig_src = 7'h00;
		bad_count = 0;
		num_checks = 0;
		void'($urandom(19));
		repeat (2) @(posedge mclk);
		reset_n <= 1'h1;
		repeat (3) @(posedge mclk);
		// reset values, then an unmapped word
		for (int a = 0; a < 7; a++)
		begin
			apb(1'h0, 8'(a * 4), 32'h0);
			chk(rd, 32'h0);
			chk(32'(err), 32'(a == 6));
		end
		// selections wait for the enable bit
		apb(1'h1, 8'h00, 32'h1F);
		chk(32'(ana_channel), 32'h0);
		apb(1'h1, 8'h04, 32'h80);
		apb(1'h1, 8'h14, 32'h07);
		// misc lands at the access edge and reaches the pins one edge later
		repeat (2) @(posedge mclk);
		chk(32'(ana_channel), 32'h1F);
		chk(32'({ana_ref_ext, ana_ref_out, ana_current_source_pin_en}), 32'h7);
		// single conversions, channel moved while converting
		for (int i = 0; i < 4; i++)
		begin
			ch = 5'($urandom());
			rf = 2'($urandom());
			apb(1'h1, 8'h00, 32'({rf, i[0], ch}));
			apb(1'h1, 8'h04, 32'hC8);
			apb(1'h0, 8'h04, 32'h0);
			chk(32'(rd[6]), 32'h1);
			apb(1'h1, 8'h00, 32'({rf, i[0], ~ch}));
			wait_done();
			chk(32'(rd[6]), 32'h0);
			code = expc(ch, rf);
			apb(1'h0, 8'h0C, 32'h0);
			chk(rd, i[0] ? 32'({code[1:0], 6'h0}) : 32'(code[7:0]));
			chk(32'(conv_irq), 32'h1);
			apb(1'h0, 8'h10, 32'h0);
			chk(rd, i[0] ? 32'(code[9:2]) : 32'(code[9:8]));
			chk(32'(ana_channel), 32'(ch ^ 5'h1F));
			apb(1'h1, 8'h04, 32'h98);
			repeat (2) @(posedge mclk);
			chk(32'(conv_irq), 32'h0);
		end
		// low byte read locks out the next completion
		apb(1'h0, 8'h0C, 32'h0);
		apb(1'h1, 8'h00, 32'h05);
		apb(1'h1, 8'h04, 32'hC0);
		wait_done();
		chk(32'(rd[4]), 32'h1);
		apb(1'h0, 8'h10, 32'h0);
		chk(rd, 32'(code[9:8]));
		apb(1'h1, 8'h04, 32'hD0);
		wait_done();
		code = expc(5'h05, 2'h0);
		apb(1'h0, 8'h0C, 32'h0);
		chk(rd, 32'(code[7:0]));
		apb(1'h0, 8'h10, 32'h0);
		chk(rd, 32'(code[9:8]));
		// auto trigger from source code 1, extra edge mid-conversion, level held after
		apb(1'h1, 8'h08, 32'h01);
		apb(1'h1, 8'h04, 32'hB0);
		@(posedge mclk);
		trig_src <= {6'($urandom()), 1'h1};
		repeat (6) @(posedge mclk);
		apb(1'h0, 8'h04, 32'h0);
		chk(32'(rd[6]), 32'h1);
		trig_src[0] <= 1'h0;
		repeat (3) @(posedge mclk);
		trig_src[0] <= 1'h1;
		wait_done();
		apb(1'h1, 8'h04, 32'hB0);
		repeat (80) @(posedge mclk);
		apb(1'h0, 8'h04, 32'h0);
		chk(32'(rd[6:4]), 32'h2);
		// free running from its own flag, first start by software
		apb(1'h1, 8'h08, 32'h00);
		apb(1'h1, 8'h04, 32'hE0);
		wait_done();
		apb(1'h1, 8'h04, 32'hB0);
		apb(1'h0, 8'h04, 32'h0);
		chk(32'(rd[6]), 32'h1);
		wait_done();
		chk(32'(rd[4]), 32'h1);
		// disabled: start writes have no effect
		apb(1'h1, 8'h04, 32'h00);
		apb(1'h1, 8'h04, 32'h40);
		apb(1'h0, 8'h04, 32'h0);
		chk(32'(rd[6]), 32'h0);
		chk(32'(ana_enable), 32'h0);
		end_of_test();
	end
endmodule // sacc_top_tb_top
